// >>> verilog/pmr_map.vh
/*
 * Register offsets, field positions, reset values and scaling shifts of the
 * power monitor result register bank.
 * Assumes it is included once per compile unit by its bare name.
 */
`ifndef PMR_MAP_VH
`define PMR_MAP_VH

// Register offsets (4-bit register index)
`define PMR_OFS_DEVICE_CFG 4'h0
`define PMR_OFS_CONVERTER_CFG 4'h1
`define PMR_OFS_SHUNT_SCALE 4'h2
`define PMR_OFS_SHUNT_V 4'h4
`define PMR_OFS_BUS_V 4'h5
`define PMR_OFS_DIE_TEMP 4'h6
`define PMR_OFS_CURRENT 4'h7
`define PMR_OFS_POWER 4'h8
`define PMR_OFS_DIAG_ALERT 4'hb

// Field positions
`define PMR_BIT_RANGE_SEL 4
`define PMR_AVG_MSB 2
`define PMR_BIT_ALERT_LATCH 15
`define PMR_BIT_READY_ROUTE 14
`define PMR_BIT_ALERT_POL 12
`define PMR_BIT_FAULT_FLAG 10
`define PMR_BIT_DONE_FLAG 1
`define PMR_BIT_MEM_OK 0

// Reset values
`define PMR_RST_SHUNT_SCALE 15'h1000
`define PMR_RST_AVG 3'h0

// Arithmetic scaling shifts
`define PMR_CURRENT_SHIFT 11
`define PMR_POWER_SHIFT 4

`endif

// >>> verilog/pmr_result_regs.v
/*
 * Result register bank of a current, voltage and power monitor: averaging,
 * current and power arithmetic, result registers and the diagnostic/alert
 * register with its latch, routing and open-drain alert pin.
 * Assumes a serial front end on the same clock presents one register
 * access per strobe, and that converter samples and limit faults arrive
 * as same-clock logic signals.
 * Limitation: a new averaging code takes effect at once; the run then in
 * progress closes early or late and gives one mixed average.
 */
// How it works
// (R1) Averaging code 0..7 picks 1..1024 samples
// (R2) One averaging count serves every enabled input
// (R3) Results change only when averaging run completes
// (R4) Shunt scale: 15 writable bits, reset 1000h
// (R5) Shunt scale multiplies shunt voltage into current
// (R6) Shunt result signed 16-bit, range picks step; here the step is fixed, range_sel unused
// (R7) Bus result 16-bit, never negative
// (R8) Temperature in bits 15-4, low nibble zero
// (R9) Current result read-only signed 16-bit
// (R10) Power result read-only unsigned 24-bit
// (R11) Transparent alert follows the fault directly
// (R12) Latched alert holds until diagnostic read
// (R13) Routing bit sends done flag to alert
// (R14) Range bit selects shunt full-scale range; here the bit is only stored and read back
// (R15) Done flag set per run, cleared latched
// (R16) Polarity bit picks alert level, open drain
// (R17) Writes to read-only bits are ignored
// (R18) Results read zero until first run ends
`default_nettype none
`include "pmr_map.vh"

module pmr_result_regs #(
    parameter SAMPLE_W = 16, // Converter sample width
    parameter ACC_W = 26 // Sample width plus ten bits for 1024 samples
) (
    input wire core_clk_in, // Device clock, 50 MHz
    input wire nrst_in, // Synchronous reset, active low
    input wire [3:0] reg_addr_in, // Register index from serial front end
    input wire reg_wr_in, // Write strobe, one cycle
    input wire reg_rd_in, // Read strobe, one cycle
    input wire [23:0] reg_wdata_in, // Write data, low bits used
    output reg [23:0] reg_rdata_out, // Read data, valid cycle after strobe
    input wire sample_valid_in, // One set of converter samples ready
    input wire [2:0] chan_enable_in, // Enabled inputs: 0 shunt, 1 bus, 2 temp
    input wire [SAMPLE_W-1:0] shunt_sample_in, // Signed shunt sample
    input wire [SAMPLE_W-1:0] bus_sample_in, // Bus sample, non-negative
    input wire [SAMPLE_W-1:0] temp_sample_in, // Signed temperature, 12 bits used
    input wire trigger_in, // New triggered conversion started
    input wire fault_in, // Limit comparator fault level
    output reg alert_out, // Alert pin output value (always low)
    output reg alert_oe_out // Alert pin pull-down enable
);

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    reg range_sel; // Shunt full-scale range select
    reg [2:0] avg_sel; // Averaging count select
    reg [14:0] shunt_scale; // Shunt calibration constant
    reg latch_en; // Alert latch enable
    reg ready_route; // Done flag routed to alert
    reg alert_pol; // Alert polarity
    reg done_flag; // Conversion complete flag
    reg fault_flag; // Alert flag

    // Result registers
    // All reset to zero and read-only to the host
    reg [15:0] shunt_res;
    reg [15:0] bus_res;
    reg [15:0] temp_res;
    reg [15:0] current_res;
    reg [23:0] power_res;

    // Averaging state
    reg [10:0] sample_cnt; // Samples taken in the current run
    reg [10:0] run_len; // Samples needed for this code
    reg [3:0] avg_shift; // log2 of run length
    // Sums including the present sample; one per input so a single run
    // count can close all of them on the same edge
    wire [ACC_W-1:0] next_acc [0:2];
    wire [SAMPLE_W-1:0] samples [0:2];
    wire [SAMPLE_W-1:0] avg_val [0:2]; // Averaged values at run end
    wire run_end;
    wire diag_read;

    assign samples[0] = shunt_sample_in;
    assign samples[1] = bus_sample_in;
    assign samples[2] = temp_sample_in;
    // Greater-or-equal closes a run at once if the code shrinks mid-run;
    // an exact compare would let the count wrap and stall the results
    assign run_end = sample_valid_in && (sample_cnt >= run_len - 11'h001); // (R3)
    assign diag_read = reg_rd_in && (reg_addr_in == `PMR_OFS_DIAG_ALERT);

    ////////////////////////////////////////////////////////////////////////
    // Decode the averaging code into length and shift
    always @* begin
        // Shift is log2 of the run length, so the divide is a plain shift
        case (avg_sel) // (R1)
            3'h0: begin
                avg_shift = 4'h0; // 1 sample
            end
            3'h1: begin
                avg_shift = 4'h2; // 4 samples
            end
            3'h2: begin
                avg_shift = 4'h4; // 16 samples
            end
            3'h3: begin
                avg_shift = 4'h6; // 64 samples
            end
            3'h4: begin
                avg_shift = 4'h7; // 128 samples
            end
            3'h5: begin
                avg_shift = 4'h8; // 256 samples
            end
            3'h6: begin
                avg_shift = 4'h9; // 512 samples
            end
            default: begin
                avg_shift = 4'ha; // 1024 samples
            end
        endcase
        run_len = 11'h001 << avg_shift;
    end

    ////////////////////////////////////////////////////////////////////////
    // One accumulator per input, all sharing the same run count
    // A disabled input keeps its accumulator cleared and its result frozen;
    // the run count still advances so enabled inputs stay in step
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_acc
            reg [ACC_W-1:0] sum;
            wire [ACC_W-1:0] ext;
            wire [ACC_W-1:0] shifted;
            // Sign extend so signed inputs average correctly
            assign ext = {{(ACC_W-SAMPLE_W){samples[ch][SAMPLE_W-1]}}, samples[ch]};
            assign next_acc[ch] = sum + ext;
            // Arithmetic shift keeps negative averages negative
            assign shifted = $signed(next_acc[ch]) >>> avg_shift;
            assign avg_val[ch] = shifted[SAMPLE_W-1:0];
            // Accumulate while enabled; restart at each run end
            always @(posedge core_clk_in) begin
                if (!nrst_in) begin
                    sum <= {ACC_W{1'b0}};
                end else if (sample_valid_in) begin
                    if (run_end || !chan_enable_in[ch]) begin
                        sum <= {ACC_W{1'b0}}; // (R2)
                    end else begin
                        sum <= next_acc[ch]; // (R2)
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Current and power arithmetic from the averaged values
    // Current is the shunt average times the scale constant, shifted down;
    // the scale therefore sets the weight of one current count
    // Both products are cut to their register widths on purpose
    wire signed [31:0] current_prod;
    wire [15:0] bus_clamp; // Bus average with negatives forced to zero
    wire [31:0] current_wide;
    wire [15:0] next_current;
    wire [15:0] current_mag;
    wire [31:0] power_prod;
    wire [31:0] power_wide;
    assign current_prod = $signed(avg_val[0]) * $signed({1'b0, shunt_scale}); // (R5)
    assign current_wide = current_prod >>> `PMR_CURRENT_SHIFT;
    assign next_current = current_wide[15:0];
    // Power is a magnitude, so the current sign is dropped
    assign current_mag = next_current[15] ? (16'h0000 - next_current) : next_current;
    // A negative bus average is reported as zero, so power uses the same
    // clamped value rather than a huge unsigned reading
    assign bus_clamp = avg_val[1][15] ? 16'h0000 : avg_val[1]; // (R7)
    assign power_prod = current_mag * bus_clamp; // (R10)
    assign power_wide = power_prod >> `PMR_POWER_SHIFT;

    ////////////////////////////////////////////////////////////////////////
    // Run counter and result update
    // Results load together on the closing sample only, so a host read in
    // mid-run always sees the previous complete average
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            sample_cnt <= 11'h000;
            shunt_res <= 16'h0000; // (R18)
            bus_res <= 16'h0000; // (R18)
            temp_res <= 16'h0000; // (R18)
            current_res <= 16'h0000; // (R18)
            power_res <= 24'h000000; // (R18)
        end else if (sample_valid_in) begin
            if (run_end) begin
                sample_cnt <= 11'h000;
                // Only enabled inputs refresh; the rest keep old values
                if (chan_enable_in[0]) begin
                    shunt_res <= avg_val[0]; // (R6)
                    current_res <= next_current; // (R9)
                end
                if (chan_enable_in[1]) begin
                    bus_res <= bus_clamp; // (R7)
                end
                if (chan_enable_in[0] && chan_enable_in[1]) begin
                    power_res <= power_wide[23:0]; // (R10)
                end
                if (chan_enable_in[2]) begin
                    temp_res <= {avg_val[2][11:0], 4'h0}; // (R8)
                end
            end else begin
                sample_cnt <= sample_cnt + 11'h001; // (R3)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written control bits
    // Only the fields below are writable; result offsets fall to default,
    // so host writes there cannot disturb a result
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            range_sel <= 1'b0;
            avg_sel <= `PMR_RST_AVG;
            shunt_scale <= `PMR_RST_SHUNT_SCALE; // (R4)
            latch_en <= 1'b0;
            ready_route <= 1'b0;
            alert_pol <= 1'b0;
        end else if (reg_wr_in) begin
            case (reg_addr_in) // (R17)
                `PMR_OFS_DEVICE_CFG: begin
                    range_sel <= reg_wdata_in[`PMR_BIT_RANGE_SEL]; // (R14)
                end
                `PMR_OFS_CONVERTER_CFG: begin
                    avg_sel <= reg_wdata_in[`PMR_AVG_MSB:0];
                end
                `PMR_OFS_SHUNT_SCALE: begin
                    shunt_scale <= reg_wdata_in[14:0]; // (R4)
                end
                `PMR_OFS_DIAG_ALERT: begin
                    latch_en <= reg_wdata_in[`PMR_BIT_ALERT_LATCH];
                    ready_route <= reg_wdata_in[`PMR_BIT_READY_ROUTE];
                    alert_pol <= reg_wdata_in[`PMR_BIT_ALERT_POL];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Done and fault flags; a new event beats a clear in the same cycle
    // Latched mode: the fault flag holds until a diagnostic read with the
    // fault gone; a fault still present at the read keeps it set
    // Transparent mode: the fault flag simply follows the fault level
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            done_flag <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            if (sample_valid_in && run_end) begin
                done_flag <= 1'b1; // (R15)
            end else if (latch_en && (diag_read || trigger_in)) begin
                done_flag <= 1'b0; // (R15)
            end else if (!latch_en && sample_valid_in && sample_cnt == 11'h000) begin
                done_flag <= 1'b0; // Transparent: clears as next run starts
            end
            if (!latch_en) begin
                fault_flag <= fault_in; // (R11)
            end else if (fault_in) begin
                fault_flag <= 1'b1; // (R12)
            end else if (diag_read) begin
                fault_flag <= 1'b0; // (R12)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alert pin: open drain, pulled low while enable is high
    // The value bit stays low for ever; only the enable moves, so the pin
    // is never driven high and can share a wired alert line
    wire alert_active;
    assign alert_active = fault_flag || (ready_route && done_flag); // (R13)
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            alert_out <= 1'b0;
            alert_oe_out <= 1'b0;
        end else begin
            alert_out <= 1'b0;
            // Active high releases the pin on alert and holds it low idle
            alert_oe_out <= alert_pol ? !alert_active : alert_active; // (R16)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe
    // Data holds until the next read, so the host may take it late
    // Reserved and unmapped bits read as zero
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 24'h000000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `PMR_OFS_DEVICE_CFG: begin
                    reg_rdata_out <= {19'h0, range_sel, 4'h0};
                end
                `PMR_OFS_CONVERTER_CFG: begin
                    reg_rdata_out <= {21'h0, avg_sel};
                end
                `PMR_OFS_SHUNT_SCALE: begin
                    reg_rdata_out <= {9'h0, shunt_scale}; // (R4)
                end
                `PMR_OFS_SHUNT_V: begin
                    reg_rdata_out <= {8'h00, shunt_res};
                end
                `PMR_OFS_BUS_V: begin
                    reg_rdata_out <= {8'h00, bus_res};
                end
                `PMR_OFS_DIE_TEMP: begin
                    reg_rdata_out <= {8'h00, temp_res};
                end
                `PMR_OFS_CURRENT: begin
                    reg_rdata_out <= {8'h00, current_res};
                end
                `PMR_OFS_POWER: begin
                    reg_rdata_out <= power_res;
                end
                `PMR_OFS_DIAG_ALERT: begin
                    reg_rdata_out <= {8'h00, latch_en, ready_route, 1'b0, alert_pol,
                        1'b0, fault_flag, 8'h00, done_flag, 1'b1};
                end
                default: begin
                    reg_rdata_out <= 24'h000000; // Unmapped reads as zero
                end
            endcase
        end
    end

endmodule // pmr_result_regs
`default_nettype wire

// >>> bench/pmr_result_regs_asserts.sv
/* Checker of the result register bank: read path and alert pin.
   Assumes a bind to pmr_result_regs; sees only its ports. */
`default_nettype none
module pmr_result_regs_asserts (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [23:0] reg_wdata_in,
    input wire logic [23:0] reg_rdata_out,
    input wire logic sample_valid_in,
    input wire logic fault_in,
    input wire logic alert_out,
    input wire logic alert_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the control bits, followed from host writes
    logic lat, route, pol;
    logic [2:0] averaging_count_sel;
    wire logic diag_rd = reg_rd_in && reg_addr_in == 4'hb;
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            {lat, route, pol} <= 3'h0;
            averaging_count_sel <= 3'h0;
        end else if (reg_wr_in && reg_addr_in == 4'hb) begin
            {lat, route, pol} <= {reg_wdata_in[15], reg_wdata_in[14], reg_wdata_in[12]};
        end else if (reg_wr_in && reg_addr_in == 4'h1) begin
            averaging_count_sel <= reg_wdata_in[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_pin_stays_low: assert property (alert_out == 1'b0)
        else $error("alert pin value driven high");
    chk_rdata_held: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    chk_scale_top_zero: assert property (
        reg_rd_in && reg_addr_in == 4'h2 |=> !reg_rdata_out[15])
        else $error("scale bit 15 read as one");
    chk_temp_nibble_zero: assert property (
        reg_rd_in && reg_addr_in == 4'h6 |=> reg_rdata_out[3:0] == 4'h0)
        else $error("temperature low nibble not zero");
    chk_unmapped_zero: assert property (
        reg_rd_in && reg_addr_in == 4'h3 |=> reg_rdata_out == 24'h0)
        else $error("unmapped read not zero");
    chk_fault_raises_pin: assert property (
        fault_in && !pol && !reg_wr_in |=> ##1 alert_oe_out)
        else $error("fault did not pull the pin");
    chk_fault_clears_pin: assert property (
        (!fault_in && !lat && !route && !pol && !reg_wr_in) [*2] |=> !alert_oe_out)
        else $error("transparent alert stayed active");
    chk_latch_holds_pin: assert property (
        lat && !route && !pol && alert_oe_out && !$past(reg_wr_in) && !$past(diag_rd)
        |=> alert_oe_out)
        else $error("latched alert dropped without a read");
    chk_route_done_pin: assert property (
        sample_valid_in && averaging_count_sel == 3'h0 && route && !pol && !reg_wr_in
        |=> ##1 alert_oe_out)
        else $error("ready flag not routed to pin");
    chk_pol_idle_high: assert property (
        (pol && !fault_in && !lat && !route && !reg_wr_in) [*2] |=> alert_oe_out)
        else $error("inverted idle level wrong");
    cover property (diag_rd && lat);
    cover property (fault_in ##1 !fault_in);
    cover property (sample_valid_in && averaging_count_sel == 3'h7);
endmodule // pmr_result_regs_asserts
`default_nettype wire

// >>> bench/pmr_host_model.sv
/* Register host model: single write and read strobes to the bank.
   Assumes one clock shared with the bank. */
`default_nettype none
module pmr_host_model (
    input wire logic core_clk_in,
    output var logic [3:0] addr_out,
    output var logic wr_out,
    output var logic rd_out,
    output var logic [23:0] wdata_out,
    input wire logic [23:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {addr_out, wr_out, rd_out, wdata_out} = '0;
    end
    // One-cycle strobe; data scrambled on release so stale values never match
    task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge core_clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // Answer is taken one edge after the strobe was sampled
    task automatic rd_reg(input logic [3:0] a, output logic [23:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        @(posedge core_clk_in);
        d = rdata_in;
    endtask
endmodule // pmr_host_model
`default_nettype wire

// >>> bench/power_monitor_result_regs_tb.sv
/* Testbench of the result register bank: host access, runs, alert pin.
   Assumes the host model and checker are compiled first. */
`default_nettype none
`define PMR_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module power_monitor_result_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in, nrst_in, sample_valid_in, trigger_in, fault_in;
    logic reg_wr_in, reg_rd_in, alert_out, alert_oe_out;
    logic [2:0] chan_enable_in;
    logic [3:0] reg_addr_in;
    logic [15:0] shunt_sample_in, bus_sample_in, temp_sample_in;
    logic [23:0] reg_wdata_in, reg_rdata_out;
    int checks = 0;
    int bad_count = 0;
    localparam int SH [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
    pmr_result_regs pmr_result_regs_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .sample_valid_in(sample_valid_in), .chan_enable_in(chan_enable_in),
        .shunt_sample_in(shunt_sample_in), .bus_sample_in(bus_sample_in),
        .temp_sample_in(temp_sample_in), .trigger_in(trigger_in), .fault_in(fault_in),
        .alert_out(alert_out), .alert_oe_out(alert_oe_out));
    pmr_host_model pmr_host_model_inst (.core_clk_in(core_clk_in), .addr_out(reg_addr_in),
        .wr_out(reg_wr_in), .rd_out(reg_rd_in), .wdata_out(reg_wdata_in),
        .rdata_in(reg_rdata_out));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        pmr_host_model_inst.wr_reg(a, d);
    endtask
    task automatic rx(input logic [3:0] a, input logic [23:0] e);
        logic [23:0] d;
        pmr_host_model_inst.rd_reg(a, d);
        `PMR_CHK($sformatf("register %h", a), e, d)
    endtask
    // Pin settles two edges after its cause, so look three falling edges on
    task automatic pin(input logic e);
        repeat (3) @(negedge core_clk_in);
        `PMR_CHK("alert enable", e, alert_oe_out)
    endtask
    // One sample set; lines are inverted once released
    task automatic samp(input logic [15:0] s, input logic [15:0] b, input logic [15:0] t);
        @(posedge core_clk_in);
        sample_valid_in <= 1'b1;
        {shunt_sample_in, bus_sample_in, temp_sample_in} <= {s, b, t};
        @(posedge core_clk_in);
        sample_valid_in <= 1'b0;
        {shunt_sample_in, bus_sample_in, temp_sample_in} <= ~{s, b, t};
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_access();
        rx(4'h2, 24'h001000);
        rx(4'hb, 24'h000001);
        wr(4'h0, 24'h000010);
        rx(4'h0, 24'h000010);
        wr(4'h0, 24'h0);
        rx(4'h0, 24'h0);
        for (int a = 4; a <= 8; a++) rx(a[3:0], 24'h0);
        wr(4'h2, 24'hffffff);
        rx(4'h2, 24'h007fff);
        wr(4'h7, 24'h001234);
        rx(4'h7, 24'h0);
        rx(4'h3, 24'h0);
        wr(4'h2, 24'h001000);
    endtask
    task automatic t_calc();
        samp(16'h0100, 16'h0080, 16'h0123);
        rx(4'h4, 24'h000100);
        rx(4'h5, 24'h000080);
        rx(4'h6, 24'h001230);
        rx(4'h7, 24'h000200);
        rx(4'h8, 24'h001000);
        rx(4'hb, 24'h000003);
        wr(4'h2, 24'h000800);
        samp(16'hff00, 16'h0080, 16'h0ff0);
        rx(4'h7, 24'h00ff00);
        rx(4'h8, 24'h000800);
    endtask
    // Every averaging code; result must not move before the run's last sample
    task automatic t_avg();
        logic [15:0] prev, v;
        int n;
        prev = 16'hff00;
        for (int c = 0; c < 8; c++) begin
            n = 1 << SH[c];
            v = 16'h0010 + 16'(c);
            wr(4'h1, 24'(c));
            for (int i = 0; i < n - 1; i++) samp(v + 16'(2 * (i & 1)), v, 16'h0);
            rx(4'h4, {8'h0, prev});
            samp(v + 16'(2 * ((n - 1) & 1)), v, 16'h0);
            prev = (n == 1) ? v : v + 16'h1;
            rx(4'h4, {8'h0, prev});
            rx(4'h5, {8'h0, v});
        end
        wr(4'h1, 24'h0);
    endtask
    task automatic t_alert();
        logic [23:0] d;
        @(posedge core_clk_in);
        fault_in <= 1'b1;
        pin(1'b1);
        @(posedge core_clk_in);
        fault_in <= 1'b0;
        pin(1'b0);
        wr(4'hb, 24'h001000);
        pin(1'b1);
        wr(4'hb, 24'h008000);
        @(posedge core_clk_in);
        fault_in <= 1'b1;
        @(posedge core_clk_in);
        fault_in <= 1'b0;
        pin(1'b1);
        pmr_host_model_inst.rd_reg(4'hb, d);
        `PMR_CHK("latched flags", 2'b11, {d[10], d[1]})
        pin(1'b0);
        pmr_host_model_inst.rd_reg(4'hb, d);
        `PMR_CHK("cleared flags", 2'b00, {d[10], d[1]})
        wr(4'hb, 24'h004000);
        samp(16'h0, 16'h0, 16'h0);
        pin(1'b1);
        wr(4'hb, 24'h0);
        pin(1'b0);
        wr(4'hb, 24'h00c000);
        @(posedge core_clk_in);
        trigger_in <= 1'b1;
        @(posedge core_clk_in);
        trigger_in <= 1'b0;
        pin(1'b0);
    endtask
    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        {nrst_in, sample_valid_in, trigger_in, fault_in} = 4'h0;
        chan_enable_in = 3'h7;
        {shunt_sample_in, bus_sample_in, temp_sample_in} = '0;
        repeat (12) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        t_access();
        t_calc();
        t_avg();
        t_alert();
        test_done();
    end
endmodule // power_monitor_result_regs_tb
bind pmr_result_regs pmr_result_regs_asserts pmr_result_regs_asserts_inst (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
    .fault_in(fault_in), .alert_out(alert_out), .alert_oe_out(alert_oe_out));
`undef PMR_CHK
`default_nettype wire
